//--- design/tfg_gasket.sv
/*
 bus timeout flush gasket top: times read and write commands, flushes
 them with time-out errors, drops unexpected responses, counts errors.
 assumes one clock, synchronous reset, Avalon-MM register master, and a
 source side that accepts responses every cycle.
*/
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module tfg_gasket #(
  parameter int IDS = 16,
  parameter logic [tfg_pkg::TMR_W-1:0] PERIOD_DEFAULT =
    tfg_pkg::PERIOD_RESET
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // avalon-mm register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // source side commands in
  input wire tfg_pkg::tfg_cmd_t src_rd_cmd,
  input wire tfg_pkg::tfg_cmd_t src_wr_cmd,
  input wire logic src_wdata_valid,
  input wire logic [31:0] src_wdata,
  output logic src_wdata_ready,
  // destination side
  output tfg_pkg::tfg_cmd_t dst_rd_cmd,
  output tfg_pkg::tfg_cmd_t dst_wr_cmd,
  output logic dst_wdata_valid,
  output logic [31:0] dst_wdata,
  input wire logic dst_wdata_ready,
  input wire tfg_pkg::tfg_resp_t dst_rd_resp,
  input wire logic [31:0] dst_rd_data,
  input wire tfg_pkg::tfg_resp_t dst_wr_resp,
  // source side responses out
  output tfg_pkg::tfg_resp_t src_rd_resp,
  output logic [31:0] src_rd_data,
  output tfg_pkg::tfg_resp_t src_wr_resp,
  // interrupt
  output logic irq
);
  if (PERIOD_DEFAULT == '0) begin : g_bad_period
    $error("period default must be non-zero");
  end

  logic rd_match;
  logic rd_unexp;
  logic rd_to;
  logic [tfg_pkg::ID_W-1:0] rd_to_id;
  logic [tfg_pkg::ADDR_W-1:0] rd_to_addr;
  logic rd_to_dbg;
  logic wr_match;
  logic wr_unexp;
  logic wr_to;
  logic [tfg_pkg::ID_W-1:0] wr_to_id;
  logic [tfg_pkg::ADDR_W-1:0] wr_to_addr;
  logic wr_to_dbg;

  logic [tfg_pkg::TMR_W-1:0] period;
  logic [tfg_pkg::CNT_W-1:0] to_cnt;
  logic [tfg_pkg::CNT_W-1:0] ux_cnt;
  logic [31:0] cap_addr;
  logic [31:0] cap_info;
  logic [tfg_pkg::ST_W-1:0] status;
  logic [tfg_pkg::ST_W-1:0] mask;
  logic [tfg_pkg::TMR_W-1:0] next_period;
  logic [tfg_pkg::CNT_W-1:0] next_to_cnt;
  logic [tfg_pkg::CNT_W-1:0] next_ux_cnt;
  logic [31:0] next_cap_addr;
  logic [31:0] next_cap_info;
  logic [tfg_pkg::ST_W-1:0] next_status;
  logic [tfg_pkg::ST_W-1:0] next_mask;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic [1:0] next_avs_response;
  logic next_irq;

  tfg_pkg::tfg_resp_t next_src_rd_resp;
  tfg_pkg::tfg_resp_t next_src_wr_resp;
  logic [31:0] next_src_rd_data;

  tfg_tracker #(.IDS(IDS)) u_rd (
    .sys_clk(sys_clk),
    .reset(reset),
    .cmd(src_rd_cmd),
    .dst_resp(dst_rd_resp),
    .period(period),
    .resp_match(rd_match),
    .resp_unexp(rd_unexp),
    .timeout(rd_to),
    .timeout_id(rd_to_id),
    .timeout_addr(rd_to_addr),
    .timeout_debug(rd_to_dbg)
  );

  tfg_tracker #(.IDS(IDS)) u_wr (
    .sys_clk(sys_clk),
    .reset(reset),
    .cmd(src_wr_cmd),
    .dst_resp(dst_wr_resp),
    .period(period),
    .resp_match(wr_match),
    .resp_unexp(wr_unexp),
    .timeout(wr_to),
    .timeout_id(wr_to_id),
    .timeout_addr(wr_to_addr),
    .timeout_debug(wr_to_dbg)
  );

  // sum of concurrent events, saturating at the maximum
  function automatic logic [tfg_pkg::CNT_W-1:0] sat_add(
    input logic [tfg_pkg::CNT_W-1:0] cnt,
    input logic a,
    input logic b
  );
    logic [tfg_pkg::CNT_W:0] sum;
    sum = {1'b0, cnt} + {2'h0, a} + {2'h0, b};
    if (sum > {1'b0, tfg_pkg::CNT_MAX}) begin
      sat_add = tfg_pkg::CNT_MAX;
    end else begin
      sat_add = sum[tfg_pkg::CNT_W-1:0];
    end
  endfunction : sat_add

  // response path: matched responses pass unless a timeout is reported that cycle; timeouts auto-respond
  always_comb begin
    next_src_rd_resp = '0;
    next_src_wr_resp = '0;
    next_src_rd_data = '0;
    if (rd_to) begin
      next_src_rd_resp.valid = 1'b1;
      next_src_rd_resp.id = rd_to_id;
      next_src_rd_resp.status = tfg_pkg::RESP_TIMEOUT;
    end else if (rd_match) begin
      next_src_rd_resp = dst_rd_resp;
      next_src_rd_data = dst_rd_data;
    end
    if (wr_to) begin
      // debug writes get the same error, never success
      next_src_wr_resp.valid = 1'b1;
      next_src_wr_resp.id = wr_to_id;
      next_src_wr_resp.status = tfg_pkg::RESP_TIMEOUT;
    end else if (wr_match) begin
      next_src_wr_resp = dst_wr_resp;
    end
  end

  // register file and error bookkeeping
  always_comb begin
    logic clr;
    logic [31:0] wd;
    clr = 1'b0;
    wd = avs_writedata;
    next_period = period;
    next_mask = mask;
    next_readdata = '0;
    next_avs_response = tfg_pkg::AVS_RESP_OK;
    next_waitrequest = 1'b1;
    next_to_cnt = sat_add(to_cnt, rd_to, wr_to);
    next_ux_cnt = sat_add(ux_cnt, rd_unexp, wr_unexp);
    next_cap_addr = cap_addr;
    next_cap_info = cap_info;
    next_status = status;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_waitrequest = 1'b0;
      unique case (avs_address)
        tfg_pkg::OFS_PERIOD: begin
          next_readdata = period;
          if (avs_write) begin
            for (int b = 0; b < 4; b++) begin
              if (avs_byteenable[b]) begin
                next_period[b*8 +: 8] = wd[b*8 +: 8];
              end
            end
          end
        end
        tfg_pkg::OFS_COUNT: begin
          next_readdata[tfg_pkg::CNT_TO_LSB +: tfg_pkg::CNT_W] = to_cnt;
          next_readdata[tfg_pkg::CNT_UX_LSB +: tfg_pkg::CNT_W] = ux_cnt;
          clr = avs_write && avs_byteenable[3]
                && wd[tfg_pkg::CNT_CLEAR_BIT];
        end
        tfg_pkg::OFS_CAP_ADDR: next_readdata = cap_addr;
        tfg_pkg::OFS_CAP_INFO: next_readdata = cap_info;
        tfg_pkg::OFS_STATUS: begin
          next_readdata[tfg_pkg::ST_W-1:0] = status;
          if (avs_write && avs_byteenable[0]) begin
            next_status = status & ~wd[tfg_pkg::ST_W-1:0];
          end
        end
        tfg_pkg::OFS_MASK: begin
          next_readdata[tfg_pkg::ST_W-1:0] = mask;
          if (avs_write && avs_byteenable[0]) begin
            next_mask = wd[tfg_pkg::ST_W-1:0];
          end
        end
        default: next_avs_response = tfg_pkg::AVS_RESP_ERR;
      endcase
    end
    if (clr) begin
      // clear also re-arms the single capture record
      next_to_cnt = sat_add('0, rd_to, wr_to);
      next_ux_cnt = sat_add('0, rd_unexp, wr_unexp);
      next_cap_info = '0;
    end
    // a timeout in the clear cycle is still captured
    if ((rd_to || wr_to) && !next_cap_info[tfg_pkg::INFO_VALID_BIT]) begin
      next_cap_info = '0;
      next_cap_info[tfg_pkg::INFO_VALID_BIT] = 1'b1;
      if (rd_to) begin
        next_cap_addr = rd_to_addr;
        next_cap_info[tfg_pkg::ID_W-1:0] = rd_to_id;
        next_cap_info[tfg_pkg::INFO_DEBUG_BIT] = rd_to_dbg;
      end else begin
        next_cap_addr = wr_to_addr;
        next_cap_info[tfg_pkg::ID_W-1:0] = wr_to_id;
        next_cap_info[tfg_pkg::INFO_WRITE_BIT] = 1'b1;
        next_cap_info[tfg_pkg::INFO_DEBUG_BIT] = wr_to_dbg;
      end
    end
    // event set wins over software clear
    if (rd_to || wr_to) begin
      next_status[tfg_pkg::ST_TIMEOUT] = 1'b1;
    end
    if (rd_unexp || wr_unexp) begin
      next_status[tfg_pkg::ST_UNEXP] = 1'b1;
    end
    next_irq = ((next_to_cnt != '0) || (next_ux_cnt != '0))
               && |(next_status & next_mask);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      period <= PERIOD_DEFAULT;
      mask <= '1;
      to_cnt <= '0;
      ux_cnt <= '0;
      cap_addr <= '0;
      cap_info <= '0;
      status <= '0;
      avs_readdata <= '0;
      avs_waitrequest <= 1'b1;
      avs_response <= tfg_pkg::AVS_RESP_OK;
      irq <= 1'b0;
      src_rd_resp <= '0;
      src_wr_resp <= '0;
      src_rd_data <= '0;
    end else begin
      period <= next_period;
      mask <= next_mask;
      to_cnt <= next_to_cnt;
      ux_cnt <= next_ux_cnt;
      cap_addr <= next_cap_addr;
      cap_info <= next_cap_info;
      status <= next_status;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
      avs_response <= next_avs_response;
      irq <= next_irq;
      src_rd_resp <= next_src_rd_resp;
      src_wr_resp <= next_src_wr_resp;
      src_rd_data <= next_src_rd_data;
    end
  end

  // command and write data path, one register stage; the write data
  // ready never depends on timeout state, so a flush cannot stall it
  logic wd_full;
  logic next_wd_full;
  logic [31:0] next_wd;
  always_comb begin
    next_wd_full = wd_full;
    next_wd = dst_wdata;
    if (wd_full && dst_wdata_ready) begin
      next_wd_full = 1'b0;
    end
    if (src_wdata_valid && src_wdata_ready) begin
      next_wd_full = 1'b1;
      next_wd = src_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wd_full <= 1'b0;
      dst_wdata <= '0;
      dst_wdata_valid <= 1'b0;
      src_wdata_ready <= 1'b0;
      dst_rd_cmd <= '0;
      dst_wr_cmd <= '0;
    end else begin
      wd_full <= next_wd_full;
      dst_wdata <= next_wd;
      dst_wdata_valid <= next_wd_full;
      src_wdata_ready <= !next_wd_full;
      dst_rd_cmd <= src_rd_cmd;
      dst_wr_cmd <= src_wr_cmd;
    end
  end
endmodule : tfg_gasket

//--- design/tfg_pkg.sv
/*
 package for the bus timeout flush gasket: register map, field layouts,
 reset values, command and response carriers.
 assumes a single synchronous clock domain at 100 MHz.
*/
// Operation
// - flushed responses carry time-out error status
// - flushed debug writes also return time-out error
// - two timeouts same cycle add two
// - two unexpected responses same cycle add two
// - both counters saturate at three
// - capture only the first timed-out transaction
// - unmatched destination responses are dropped
// - period programmable, default 3 x 2^30 cycles
// - keep accepting write data through flush
// - each outstanding command timed individually
package tfg_pkg;
  localparam int ID_W = 4;
  localparam int ADDR_W = 32;
  localparam int TMR_W = 32;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] CNT_MAX = 2'h3;
  localparam logic [TMR_W-1:0] PERIOD_RESET = 32'hC000_0000;
  // response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_TIMEOUT = 2'h2;
  // register bus response codes
  localparam logic [1:0] AVS_RESP_OK = 2'h0;
  localparam logic [1:0] AVS_RESP_ERR = 2'h2;
  // register offsets (byte addresses)
  localparam logic [4:0] OFS_PERIOD = 5'h00;
  localparam logic [4:0] OFS_COUNT = 5'h04;
  localparam logic [4:0] OFS_CAP_ADDR = 5'h08;
  localparam logic [4:0] OFS_CAP_INFO = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_MASK = 5'h14;
  // status bit positions
  localparam int ST_TIMEOUT = 0;
  localparam int ST_UNEXP = 1;
  localparam int ST_W = 2;
  // count and capture info register fields
  localparam int CNT_TO_LSB = 0;
  localparam int CNT_UX_LSB = 8;
  localparam int CNT_CLEAR_BIT = 31;
  localparam int INFO_VALID_BIT = 31;
  localparam int INFO_WRITE_BIT = 8;
  localparam int INFO_DEBUG_BIT = 9;

  typedef struct packed {
    logic valid;
    logic [ID_W-1:0] id;
    logic [ADDR_W-1:0] addr;
    logic debug;
  } tfg_cmd_t;

  typedef struct packed {
    logic valid;
    logic [ID_W-1:0] id;
    logic [1:0] status;
  } tfg_resp_t;
endpackage : tfg_pkg

//--- design/tfg_tracker.sv
/*
 per-direction tracker of outstanding commands, one timer per id.
 assumes ids are unique among outstanding commands of one direction.
*/
`timescale 1ns/1ps
module tfg_tracker #(
  parameter int IDS = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // command issue and destination response
  input wire tfg_pkg::tfg_cmd_t cmd,
  input wire tfg_pkg::tfg_resp_t dst_resp,
  input wire logic [tfg_pkg::TMR_W-1:0] period,
  // results
  output logic resp_match,
  output logic resp_unexp,
  output logic timeout,
  output logic [tfg_pkg::ID_W-1:0] timeout_id,
  output logic [tfg_pkg::ADDR_W-1:0] timeout_addr,
  output logic timeout_debug
);
  if (IDS != (1 << tfg_pkg::ID_W)) begin : g_bad_ids
    $error("IDS must match id width");
  end

  logic [IDS-1:0] busy;
  logic [IDS-1:0] next_busy;
  logic [IDS-1:0] expired;
  logic [tfg_pkg::TMR_W-1:0] tmr [IDS];
  logic [tfg_pkg::TMR_W-1:0] next_tmr [IDS];
  logic [tfg_pkg::ADDR_W-1:0] addr_mem [IDS];
  logic [IDS-1:0] dbg_mem;

  genvar g;
  generate
    for (g = 0; g < IDS; g++) begin : g_slot
      localparam logic [tfg_pkg::ID_W-1:0] SLOT = tfg_pkg::ID_W'(g);
      logic hit_cmd;
      logic hit_resp;
      logic hit_to;
      assign hit_cmd = cmd.valid && (cmd.id == SLOT);
      assign hit_resp = dst_resp.valid && (dst_resp.id == SLOT);
      assign hit_to = timeout && (timeout_id == SLOT);
      assign expired[g] = busy[g] && (tmr[g] >= period);
      always_comb begin
        next_busy[g] = busy[g];
        next_tmr[g] = tmr[g];
        if (busy[g]) begin
          next_tmr[g] = tmr[g] + 1'b1;
        end
        // only the reported slot retires; a late reply keeps it pending
        if (hit_to || (hit_resp && !expired[g])) begin
          next_busy[g] = 1'b0;
        end
        if (hit_cmd) begin
          next_busy[g] = 1'b1;
          next_tmr[g] = '0;
        end
      end
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          busy[g] <= 1'b0;
          tmr[g] <= '0;
          dbg_mem[g] <= 1'b0;
          addr_mem[g] <= '0;
        end else begin
          busy[g] <= next_busy[g];
          tmr[g] <= next_tmr[g];
          if (hit_cmd) begin
            dbg_mem[g] <= cmd.debug;
            addr_mem[g] <= cmd.addr;
          end
        end
      end
    end
  endgenerate

  // lowest expired id is reported; others are reported on following cycles
  always_comb begin
    timeout = 1'b0;
    timeout_id = '0;
    for (int i = IDS - 1; i >= 0; i--) begin
      if (expired[i]) begin
        timeout = 1'b1;
        timeout_id = tfg_pkg::ID_W'(i);
      end
    end
    timeout_addr = addr_mem[timeout_id];
    timeout_debug = dbg_mem[timeout_id];
  end

  // a response whose slot is idle or just expired matches nothing
  assign resp_match = dst_resp.valid && busy[dst_resp.id]
                      && !expired[dst_resp.id];
  assign resp_unexp = dst_resp.valid && !resp_match;
endmodule : tfg_tracker

//--- verif/tfg_gasket_sva.sv
/*
 checker on the gasket top ports, bound to tfg_gasket.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module tfg_gasket_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // data paths
  input wire logic src_wdata_ready,
  input wire logic dst_wdata_valid,
  input wire logic [31:0] dst_wdata,
  input wire logic dst_wdata_ready,
  input wire tfg_pkg::tfg_resp_t dst_rd_resp,
  input wire tfg_pkg::tfg_resp_t dst_wr_resp,
  input wire tfg_pkg::tfg_resp_t src_rd_resp,
  input wire tfg_pkg::tfg_resp_t src_wr_resp,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  property p_flush_rd;
    src_rd_resp.valid && !$past(dst_rd_resp.valid) |->
      src_rd_resp.status == tfg_pkg::RESP_TIMEOUT;
  endproperty
  a_flush_rd: assert property (p_flush_rd)
    else $error("rd flush status");
  property p_flush_wr;
    src_wr_resp.valid && !$past(dst_wr_resp.valid) |->
      src_wr_resp.status == tfg_pkg::RESP_TIMEOUT;
  endproperty
  a_flush_wr: assert property (p_flush_wr)
    else $error("wr flush status");
  property p_fwd_rd;
    src_rd_resp.valid && src_rd_resp.status == tfg_pkg::RESP_OKAY |->
      $past(dst_rd_resp.valid) && $past(dst_rd_resp.id) == src_rd_resp.id;
  endproperty
  a_fwd_rd: assert property (p_fwd_rd)
    else $error("rd resp unmatched");
  property p_fwd_wr;
    src_wr_resp.valid && src_wr_resp.status == tfg_pkg::RESP_OKAY |->
      $past(dst_wr_resp.valid) && $past(dst_wr_resp.id) == src_wr_resp.id;
  endproperty
  a_fwd_wr: assert property (p_fwd_wr)
    else $error("wr resp unmatched");
  property p_wstage;
    !src_wdata_ready && !$past(reset) |-> dst_wdata_valid;
  endproperty
  a_wstage: assert property (p_wstage) else $error("wdata stalled");
  property p_whold;
    dst_wdata_valid && !dst_wdata_ready |=>
      dst_wdata_valid && $stable(dst_wdata);
  endproperty
  a_whold: assert property (p_whold) else $error("wdata dropped");
  property p_irq_fall;
    $fell(irq) |-> $past(avs_write) || $past(avs_write, 2) ||
      $past(avs_write, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell alone");
  property p_bus_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("bus no answer");
  property p_bus_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_bus_one: assert property (p_bus_one) else $error("bus answer long");
  property p_unmapped;
    !avs_waitrequest && avs_response == 2'h2 |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  c_flush: cover property (src_wr_resp.valid && src_wr_resp.status == 2'h2);
  c_irq: cover property ($rose(irq));
  c_stray: cover property (dst_rd_resp.valid && dst_wr_resp.valid);
endmodule : tfg_gasket_sva

bind tfg_gasket tfg_gasket_sva u_tfg_gasket_sva (.*);

//--- verif/tfg_dst_model.sv
/*
 destination target model: answers commands two cycles later or stays
 quiet, stalls write data, injects a stray response pair on demand.
 assumes the gasket destination ports and one clock.
*/
`timescale 1ns/1ps
module tfg_dst_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // bench control
  input wire logic quiet,
  input wire logic stray,
  input wire logic stall,
  // gasket destination side
  input wire tfg_pkg::tfg_cmd_t dst_rd_cmd,
  input wire tfg_pkg::tfg_cmd_t dst_wr_cmd,
  output tfg_pkg::tfg_resp_t dst_rd_resp,
  output tfg_pkg::tfg_resp_t dst_wr_resp,
  output logic [31:0] dst_rd_data,
  output logic dst_wdata_ready
);
  tfg_pkg::tfg_resp_t rd_p, wr_p;
  assign dst_wdata_ready = !stall;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_p <= '0;
      wr_p <= '0;
      dst_rd_resp <= '0;
      dst_wr_resp <= '0;
      dst_rd_data <= '0;
    end else begin
      rd_p <= '{dst_rd_cmd.valid && !quiet, dst_rd_cmd.id, 2'h0};
      wr_p <= '{dst_wr_cmd.valid && !quiet, dst_wr_cmd.id, 2'h0};
      // stray pair uses an id that is never outstanding
      dst_rd_resp <= stray ? '{1'b1, 4'h7, 2'h0} : rd_p;
      dst_wr_resp <= stray ? '{1'b1, 4'h7, 2'h0} : wr_p;
      dst_rd_data <= rd_p.valid ? {28'h0, rd_p.id} : ~dst_rd_data;
    end
  end
endmodule : tfg_dst_model

//--- verif/tb_top.sv
/*
 self-checking bench for the timeout flush gasket and its target model.
 assumes the package, design, checker and model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] PER = 32'h14;
  logic sys_clk, reset, avs_read, avs_write, avs_waitrequest, irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, src_wdata, dst_wdata, q, a1;
  logic [31:0] src_rd_data, dst_rd_data;
  logic [3:0] avs_byteenable, id;
  logic [1:0] avs_response, last_rsp;
  logic src_wdata_valid, src_wdata_ready, dst_wdata_valid, dst_wdata_ready;
  logic quiet, stray, stall, wd_on;
  tfg_pkg::tfg_cmd_t src_rd_cmd, src_wr_cmd, dst_rd_cmd, dst_wr_cmd;
  tfg_pkg::tfg_resp_t dst_rd_resp, dst_wr_resp, src_rd_resp, src_wr_resp;
  tfg_pkg::tfg_resp_t rq[$], wq[$];
  logic [31:0] wexp[$], wgot[$], dq[$];
  int seed, k, bad_count = 0, checks = 0, cyc = 0;

  tfg_gasket #(.IDS(16), .PERIOD_DEFAULT(PER)) u_tfg_gasket (.*);
  tfg_dst_model u_tfg_dst_model (.*);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish;
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    last_rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e,
      input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask : rdchk

  task automatic issue(input logic r, input logic w, input logic [3:0] i,
      input logic [31:0] a, input logic d);
    @(posedge sys_clk);
    src_rd_cmd <= '{r, i, a, 1'b0};
    src_wr_cmd <= '{w, i, a, d};
    @(posedge sys_clk);
    src_rd_cmd <= '0;
    src_wr_cmd <= '0;
  endtask : issue

  task automatic wait_q(input int n);
    for (int j = 0; j < 200 && rq.size() + wq.size() < n; j++) begin
      @(posedge sys_clk);
    end
  endtask : wait_q

  // read data the target model returns for an id
  function automatic logic [31:0] exp_rdata(input logic [3:0] i);
    exp_rdata = {28'h0, i};
  endfunction : exp_rdata

  task automatic take(input logic rd, input logic [3:0] i,
      input logic [1:0] st);
    tfg_pkg::tfg_resp_t g;
    logic [31:0] d;
    g = '0;
    d = 32'h0;
    if (rd && rq.size() > 0) g = rq.pop_front();
    if (rd && dq.size() > 0) d = dq.pop_front();
    if (!rd && wq.size() > 0) g = wq.pop_front();
    chk(rd ? "rd resp" : "wr resp", {25'h0, 1'b1, i, st}, {25'h0, g});
    if (rd && st == tfg_pkg::RESP_OKAY) begin
      chk("rd data", exp_rdata(i), d);
    end
  endtask : take

  // response monitor, write data driver and run limit
  always @(posedge sys_clk) begin
    if (src_rd_resp.valid === 1'b1) begin
      rq.push_back(src_rd_resp);
      dq.push_back(src_rd_data);
    end
    if (src_wr_resp.valid === 1'b1) wq.push_back(src_wr_resp);
    if (dst_wdata_valid === 1'b1 && dst_wdata_ready === 1'b1) begin
      wgot.push_back(dst_wdata);
    end
    stall <= 1'($random(seed));
    if (!reset && (!src_wdata_valid || src_wdata_ready === 1'b1)) begin
      if (src_wdata_valid) wexp.push_back(src_wdata);
      src_wdata_valid <= wd_on;
      src_wdata <= $random(seed);
    end
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  initial begin
    seed = 17;
    reset = 1'b1;
    {avs_read, avs_write, quiet, stray, stall, wd_on} = '0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    src_rd_cmd = '0;
    src_wr_cmd = '0;
    src_wdata_valid = 1'b0;
    src_wdata = 32'h0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    wd_on <= 1'b1;
    rdchk(tfg_pkg::OFS_PERIOD, PER, "period");
    rdchk(tfg_pkg::OFS_MASK, 32'h3, "mask");
    rdchk(tfg_pkg::OFS_COUNT, 32'h0, "count");
    bus(1'b1, tfg_pkg::OFS_PERIOD, 32'h10);
    rdchk(tfg_pkg::OFS_PERIOD, 32'h10, "period rw");
    repeat (6) begin
      id = 4'($random(seed));
      issue(1'b1, 1'b1, id, $random(seed), 1'b0);
      wait_q(2);
      take(1'b1, id, tfg_pkg::RESP_OKAY);
      take(1'b0, id, tfg_pkg::RESP_OKAY);
    end
    quiet <= 1'b1;
    issue(1'b1, 1'b0, 4'h3, 32'h0, 1'b0);
    repeat (15) @(posedge sys_clk);
    chk("early", 32'h0, 32'(rq.size()));
    wait_q(1);
    take(1'b1, 4'h3, tfg_pkg::RESP_TIMEOUT);
    bus(1'b1, tfg_pkg::OFS_COUNT, 32'h8000_0000);
    a1 = $random(seed);
    issue(1'b1, 1'b1, 4'h9, a1, 1'b0);
    wait_q(2);
    take(1'b1, 4'h9, tfg_pkg::RESP_TIMEOUT);
    take(1'b0, 4'h9, tfg_pkg::RESP_TIMEOUT);
    rdchk(tfg_pkg::OFS_COUNT, 32'h2, "to count");
    rdchk(tfg_pkg::OFS_CAP_ADDR, a1, "cap addr");
    issue(1'b1, 1'b1, 4'hC, $random(seed), 1'b1);
    wait_q(2);
    take(1'b1, 4'hC, tfg_pkg::RESP_TIMEOUT);
    take(1'b0, 4'hC, tfg_pkg::RESP_TIMEOUT);
    rdchk(tfg_pkg::OFS_COUNT, 32'h3, "to sat");
    rdchk(tfg_pkg::OFS_CAP_ADDR, a1, "cap keep");
    bus(1'b0, tfg_pkg::OFS_CAP_INFO, 32'h0);
    chk("cap info", 32'h8000_0009, q & 32'h8000_020F);
    for (k = 2; k <= 3; k++) begin
      stray <= 1'b1;
      @(posedge sys_clk);
      stray <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk("dropped", 32'h0, 32'(rq.size() + wq.size()));
      rdchk(tfg_pkg::OFS_COUNT, 32'(k << 8 | 3), "ux count");
    end
    chk("irq on", 32'h1, {31'h0, irq});
    bus(1'b1, tfg_pkg::OFS_MASK, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, tfg_pkg::OFS_MASK, 32'h3);
    repeat (3) @(posedge sys_clk);
    chk("irq back", 32'h1, {31'h0, irq});
    bus(1'b1, tfg_pkg::OFS_COUNT, 32'h8000_0000);
    bus(1'b1, tfg_pkg::OFS_STATUS, 32'h3);
    rdchk(tfg_pkg::OFS_COUNT, 32'h0, "cleared");
    chk("irq off", 32'h0, {31'h0, irq});
    rdchk(5'h1C, 32'h0, "unmapped");
    chk("unmapped rsp", 32'h2, {30'h0, last_rsp});
    wd_on <= 1'b0;
    for (k = 0; k < 200 && (src_wdata_valid || dst_wdata_valid); k++) begin
      @(posedge sys_clk);
    end
    repeat (2) @(posedge sys_clk);
    chk("wdata n", 32'(wexp.size()), 32'(wgot.size()));
    while (wexp.size() > 0 && wgot.size() > 0) begin
      chk("wdata", wexp.pop_front(), wgot.pop_front());
    end
    tally_and_finish;
  end
endmodule : tb_top
